// [hdl/pmcs_consts.svh]
// Constants for the power management configuration and status block.
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

`define PMCS_ADDR_IRQ_EN       8'hEC
`define PMCS_ADDR_CFG_STATUS   8'hF4
`define PMCS_ADDR_BATT_SWITCH  8'hF5
`define PMCS_ADDR_SCRATCH      8'hFB

`define PMCS_BIT_RX_WAKE       7
`define PMCS_BIT_RAIL_SOURCE   6
`define PMCS_BIT_MAIN_READY    5
`define PMCS_BIT_PLL_LOST      4
`define PMCS_BIT_REF_KEEP      3

`define PMCS_POLICY_LOW_MAIN   2'h0
`define PMCS_POLICY_MAIN_DCIN  2'h1
`define PMCS_RXF_GPIO          2'h0
`define PMCS_RXF_UART          2'h1
`define PMCS_RXF_UART_WAKE     2'h3

`define PMCS_EN_RESTORED       7
`define PMCS_EN_SAG            5
`define PMCS_EN_DCIN_ADC       3
`define PMCS_EN_BATT_MON       2
`define PMCS_EN_SWITCHOVER     1
`define PMCS_EN_DCIN_LOW       0
`define PMCS_IRQ_EN_MASK       8'hAF

`define PMCS_SYNC_W            6
`define PMCS_SI_RAIL           0
`define PMCS_SI_READY          1
`define PMCS_SI_PLL            2
`define PMCS_SI_RX             3
`define PMCS_SI_DCIN           4
`define PMCS_SI_MAINLOW        5
`define PMCS_SYNC_RST          6'h0B

`define PMCS_RST_BYTE          8'h00
`define PMCS_RD_UNMAPPED       8'h00

`endif

// [hdl/pmcs_pkg.sv]
// Types shared by the power management configuration and status block.
`include "pmcs_consts.svh"

package pmcs_pkg;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } pmcs_sfr_req_t;

  typedef struct packed {
    logic [`PMCS_SYNC_W-1:0] s1;
    logic [`PMCS_SYNC_W-1:0] s2;
    logic [`PMCS_SYNC_W-1:0] s3;
    logic [`PMCS_SYNC_W-1:0] stable;
  } pmcs_sync_state_t;

  typedef struct packed {
    logic [1:0] policy;
    logic       rxWake;
    logic       pllLost;
    logic       refKeep;
    logic [1:0] rxFunc;
    logic [7:0] irqEn;
    logic [7:0] scratch;
    logic [7:0] rdData;
    logic       irq;
    logic       refOn;
    logic       battReq;
    logic       rxUart;
    logic       rxWakeEn;
    logic       swFlagSet;
    logic       dcinFlagSet;
    logic       railPrev;
    logic       pllPrev;
    logic       rxPrev;
    logic       dcinPrev;
  } pmcs_state_t;

endpackage

// [hdl/pmcs_sync.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_sync (
  input  wire logic                    clk,     // Core clock.
  input  wire logic                    rst,     // Synchronous reset, active high.
  input  wire logic [`PMCS_SYNC_W-1:0] asyncIn, // Levels from outside the clock domain.
  output logic      [`PMCS_SYNC_W-1:0] syncOut  // Filtered synchronous levels.
);

  pmcs_pkg::pmcs_sync_state_t st_r;
  pmcs_pkg::pmcs_sync_state_t st_nxt;
  logic [`PMCS_SYNC_W-1:0]    agreed;

  // Stage one feeds only stage two; the agreement test looks at stages two and three.
  genvar gi;
  generate
    for (gi = 0; gi < `PMCS_SYNC_W; gi = gi + 1)
    begin : g_bit
      assign agreed[gi] = (st_r.s2[gi] == st_r.s3[gi]) ? st_r.s3[gi] : st_r.stable[gi];
    end
  endgenerate

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.s1     = asyncIn;
    st_nxt.s2     = st_r.s1;
    st_nxt.s3     = st_r.s2;
    st_nxt.stable = agreed;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.s1     <= `PMCS_SYNC_RST;
      st_r.s2     <= `PMCS_SYNC_RST;
      st_r.s3     <= `PMCS_SYNC_RST;
      st_r.stable <= `PMCS_SYNC_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign syncOut = st_r.stable;

endmodule // pmcs_sync

// [hdl/pmcs_top.sv]
// Power management configuration, status and sleep-mode interrupt gating.
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_top (
  input  wire logic                    clk,             // Core clock, 100 MHz.
  input  wire logic                    rst,             // Synchronous reset, active high.
  input  wire pmcs_pkg::pmcs_sfr_req_t sfrReq,          // Register access request.
  output logic                  [7:0]  sfrRdData,       // Read data, one cycle after rdEn.
  input  wire logic                    pllFaultAck,     // Pulse: PLL acknowledge written.
  input  wire logic                    deepSleep,       // Deepest sleep mode is active.
  input  wire logic             [7:0]  psmFlags,        // Power management flag register.
  input  wire logic                    railOnMainPin,   // Analog: rail fed by main supply.
  input  wire logic                    mainReadyPin,    // Analog: main supply ready.
  input  wire logic                    pllUnlockedPin,  // Analog: PLL out of lock.
  input  wire logic                    rxPin,           // Serial receive pin level.
  input  wire logic                    dcinBelowPin,    // Analog: DC input under 1.2 V.
  input  wire logic                    mainLowPin,      // Analog: main supply low.
  output logic                         psmIrq,          // Sleep-mode interrupt request.
  output logic                         refPowerOn,      // Voltage reference powered.
  output logic                         batterySwitchReq,// Request rail move to battery.
  output logic                         rxPinUart,       // Receive pin used as serial input.
  output logic                         rxWakeEnable,    // Receive edge wake-up armed.
  output logic                         switchoverSet,   // Pulse: set switchover flag.
  output logic                         dcinLowSet       // Pulse: set DC-input low flag.
);

  pmcs_pkg::pmcs_state_t   st_r;
  pmcs_pkg::pmcs_state_t   st_nxt;
  logic [`PMCS_SYNC_W-1:0] syncIn;
  logic                    railOnMain;
  logic                    mainReady;
  logic                    pllUnlocked;
  logic                    rxLevel;
  logic                    dcinBelow;
  logic                    mainLow;
  logic                    wrCfg;
  logic                    rxEdge;

  pmcs_sync pmcs_sync_inst (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({mainLowPin, dcinBelowPin, rxPin, pllUnlockedPin, mainReadyPin, railOnMainPin}),
    .syncOut (syncIn)
  );

  assign railOnMain  = syncIn[`PMCS_SI_RAIL];
  assign mainReady   = syncIn[`PMCS_SI_READY];
  assign pllUnlocked = syncIn[`PMCS_SI_PLL];
  assign rxLevel     = syncIn[`PMCS_SI_RX];
  assign dcinBelow   = syncIn[`PMCS_SI_DCIN];
  assign mainLow     = syncIn[`PMCS_SI_MAINLOW];
  assign wrCfg       = sfrReq.wrEn && (sfrReq.addr == `PMCS_ADDR_CFG_STATUS);
  assign rxEdge      = rxLevel != st_r.rxPrev;

  always_comb
  begin
    st_nxt             = st_r;
    st_nxt.railPrev    = railOnMain;
    st_nxt.pllPrev     = pllUnlocked;
    st_nxt.rxPrev      = rxLevel;
    st_nxt.dcinPrev    = dcinBelow;

    if (sfrReq.wrEn)
    begin
      case (sfrReq.addr)
        `PMCS_ADDR_IRQ_EN:
          st_nxt.irqEn = sfrReq.wrData & `PMCS_IRQ_EN_MASK;
        `PMCS_ADDR_CFG_STATUS:
        begin
          st_nxt.refKeep = sfrReq.wrData[`PMCS_BIT_REF_KEEP];
          st_nxt.rxFunc  = sfrReq.wrData[1:0];
        end
        // Upper bits are dropped, so a careless write cannot disturb the policy.
        `PMCS_ADDR_BATT_SWITCH:
          st_nxt.policy = sfrReq.wrData[1:0];
        `PMCS_ADDR_SCRATCH:
          st_nxt.scratch = sfrReq.wrData;
        default:
          st_nxt.policy = st_r.policy;
      endcase
    end

    // Writing zero to bit 7 clears the wake record; a wake edge in the same cycle wins.
    if (wrCfg && !sfrReq.wrData[`PMCS_BIT_RX_WAKE])
      st_nxt.rxWake = 1'b0;
    if (deepSleep && (st_r.rxFunc == `PMCS_RXF_UART_WAKE) && rxEdge)
      st_nxt.rxWake = 1'b1;

    if (pllFaultAck)
      st_nxt.pllLost = 1'b0;
    if (pllUnlocked && !st_r.pllPrev)
      st_nxt.pllLost = 1'b1;

    case (st_r.policy)
      `PMCS_POLICY_LOW_MAIN:
        st_nxt.battReq = mainLow;
      `PMCS_POLICY_MAIN_DCIN:
        st_nxt.battReq = mainLow && dcinBelow;
      default:
        st_nxt.battReq = 1'b0;
    endcase

    // Outside the deepest sleep mode the reference always runs.
    st_nxt.refOn       = !deepSleep || st_r.refKeep;
    st_nxt.rxUart      = st_r.rxFunc[0];
    st_nxt.rxWakeEn    = st_r.rxFunc == `PMCS_RXF_UART_WAKE;
    st_nxt.swFlagSet   = st_r.railPrev && !railOnMain;
    st_nxt.dcinFlagSet = dcinBelow && !st_r.dcinPrev;
    st_nxt.irq         = |(psmFlags & st_r.irqEn & `PMCS_IRQ_EN_MASK);

    st_nxt.rdData = `PMCS_RD_UNMAPPED;
    if (sfrReq.rdEn)
    begin
      case (sfrReq.addr)
        `PMCS_ADDR_IRQ_EN:
          st_nxt.rdData = st_r.irqEn;
        `PMCS_ADDR_CFG_STATUS:
          st_nxt.rdData = {st_r.rxWake, railOnMain, mainReady, st_r.pllLost,
                           st_r.refKeep, 1'b0, st_r.rxFunc};
        `PMCS_ADDR_BATT_SWITCH:
          st_nxt.rdData = {6'h00, st_r.policy};
        `PMCS_ADDR_SCRATCH:
          st_nxt.rdData = st_r.scratch;
        default:
          st_nxt.rdData = `PMCS_RD_UNMAPPED;
      endcase
    end
  end

  // Only power-on reset clears the scratch byte; sleep modes never touch it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.policy      <= 2'h0;
      st_r.rxWake      <= 1'b0;
      st_r.pllLost     <= 1'b0;
      st_r.refKeep     <= 1'b0;
      st_r.rxFunc      <= 2'h0;
      st_r.irqEn       <= `PMCS_RST_BYTE;
      st_r.scratch     <= `PMCS_RST_BYTE;
      st_r.rdData      <= `PMCS_RST_BYTE;
      st_r.irq         <= 1'b0;
      st_r.refOn       <= 1'b1;
      st_r.battReq     <= 1'b0;
      st_r.rxUart      <= 1'b0;
      st_r.rxWakeEn    <= 1'b0;
      st_r.swFlagSet   <= 1'b0;
      st_r.dcinFlagSet <= 1'b0;
      st_r.railPrev    <= 1'b1;
      st_r.pllPrev     <= 1'b0;
      st_r.rxPrev      <= 1'b1;
      st_r.dcinPrev    <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sfrRdData        = st_r.rdData;
  assign psmIrq           = st_r.irq;
  assign refPowerOn       = st_r.refOn;
  assign batterySwitchReq = st_r.battReq;
  assign rxPinUart        = st_r.rxUart;
  assign rxWakeEnable     = st_r.rxWakeEn;
  assign switchoverSet    = st_r.swFlagSet;
  assign dcinLowSet       = st_r.dcinFlagSet;

  property p_policy_off;
    @(posedge clk) disable iff (rst)
      st_r.policy[1] |=> !batterySwitchReq;
  endproperty
  a_policy_off: assert property (p_policy_off) else $error("switchover not disabled");

  property p_policy_main;
    @(posedge clk) disable iff (rst)
      (st_r.policy == `PMCS_POLICY_LOW_MAIN) |=> (batterySwitchReq == $past(mainLow));
  endproperty
  a_policy_main: assert property (p_policy_main) else $error("low main policy wrong");

  property p_rx_wake;
    @(posedge clk) disable iff (rst)
      (deepSleep && st_r.rxFunc == `PMCS_RXF_UART_WAKE && rxEdge) |=> st_r.rxWake;
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("receive wake not recorded");

  property p_rail_read;
    @(posedge clk) disable iff (rst)
      (sfrReq.rdEn && sfrReq.addr == `PMCS_ADDR_CFG_STATUS)
        |=> (sfrRdData[`PMCS_BIT_RAIL_SOURCE] == $past(railOnMain));
  endproperty
  a_rail_read: assert property (p_rail_read) else $error("rail source misread");

  property p_ready_read;
    @(posedge clk) disable iff (rst)
      (sfrReq.rdEn && sfrReq.addr == `PMCS_ADDR_CFG_STATUS)
        |=> (sfrRdData[`PMCS_BIT_MAIN_READY] == $past(mainReady));
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("supply ready misread");

  property p_pll_hold;
    @(posedge clk) disable iff (rst)
      (st_r.pllLost && !pllFaultAck) |=> st_r.pllLost;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("PLL fault lost before ack");

  property p_pll_set;
    @(posedge clk) disable iff (rst)
      (pllUnlocked && !st_r.pllPrev) |=> st_r.pllLost;
  endproperty
  a_pll_set: assert property (p_pll_set) else $error("PLL fault not set");

  property p_ref;
    @(posedge clk) disable iff (rst)
      (deepSleep && !st_r.refKeep) |=> !refPowerOn;
  endproperty
  a_ref: assert property (p_ref) else $error("reference on in deep sleep");

  property p_rx_func;
    @(posedge clk) disable iff (rst)
      (st_r.rxFunc == `PMCS_RXF_GPIO) |=> (!rxPinUart && !rxWakeEnable);
  endproperty
  a_rx_func: assert property (p_rx_func) else $error("GPIO mode drives receive");

  property p_irq_restored;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_RESTORED] && st_r.irqEn[`PMCS_EN_RESTORED]) |=> psmIrq;
  endproperty
  a_irq_restored: assert property (p_irq_restored) else $error("restored irq missing");

  property p_irq_sag;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_SAG] && st_r.irqEn[`PMCS_EN_SAG]) |=> psmIrq;
  endproperty
  a_irq_sag: assert property (p_irq_sag) else $error("sag irq missing");

  property p_irq_adc;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_DCIN_ADC] && st_r.irqEn[`PMCS_EN_DCIN_ADC]) |=> psmIrq;
  endproperty
  a_irq_adc: assert property (p_irq_adc) else $error("ADC monitor irq missing");

  property p_irq_batt;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_BATT_MON] && st_r.irqEn[`PMCS_EN_BATT_MON]) |=> psmIrq;
  endproperty
  a_irq_batt: assert property (p_irq_batt) else $error("battery irq missing");

  property p_irq_sw;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_SWITCHOVER] && st_r.irqEn[`PMCS_EN_SWITCHOVER]) |=> psmIrq;
  endproperty
  a_irq_sw: assert property (p_irq_sw) else $error("switchover irq missing");

  property p_irq_dcin;
    @(posedge clk) disable iff (rst)
      (psmFlags[`PMCS_EN_DCIN_LOW] && st_r.irqEn[`PMCS_EN_DCIN_LOW]) |=> psmIrq;
  endproperty
  a_irq_dcin: assert property (p_irq_dcin) else $error("DC low irq missing");

  property p_scratch;
    @(posedge clk) disable iff (rst)
      (sfrReq.wrEn && sfrReq.addr == `PMCS_ADDR_SCRATCH) ##1
        (sfrReq.rdEn && sfrReq.addr == `PMCS_ADDR_SCRATCH && !sfrReq.wrEn)
        |=> (sfrRdData == $past(sfrReq.wrData, 2));
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");

  property p_scratch_gap;
    @(posedge clk) disable iff (rst)
      (sfrReq.wrEn && sfrReq.addr == `PMCS_ADDR_SCRATCH) ##1 !sfrReq.wrEn ##1
        (sfrReq.rdEn && sfrReq.addr == `PMCS_ADDR_SCRATCH && !sfrReq.wrEn)
        |=> (sfrRdData == $past(sfrReq.wrData, 3));
  endproperty
  a_scratch_gap: assert property (p_scratch_gap) else $error("scratch lost after gap");

  property p_sw_flag;
    @(posedge clk) disable iff (rst)
      $fell(railOnMain) |=> switchoverSet;
  endproperty
  a_sw_flag: assert property (p_sw_flag) else $error("switchover flag not set");

  property p_dcin_flag;
    @(posedge clk) disable iff (rst)
      $rose(dcinBelow) |=> dcinLowSet;
  endproperty
  a_dcin_flag: assert property (p_dcin_flag) else $error("DC low flag not set");

  property p_irq_none;
    @(posedge clk) disable iff (rst)
      ((psmFlags & st_r.irqEn & `PMCS_IRQ_EN_MASK) == 8'h00) |=> !psmIrq;
  endproperty
  a_irq_none: assert property (p_irq_none) else $error("irq without enabled flag");

  property p_cov_wake;
    @(posedge clk) disable iff (rst) $rose(st_r.rxWake);
  endproperty
  c_cov_wake: cover property (p_cov_wake);

  property p_cov_pll;
    @(posedge clk) disable iff (rst) st_r.pllLost ##1 pllFaultAck ##1 !st_r.pllLost;
  endproperty
  c_cov_pll: cover property (p_cov_pll);

  property p_cov_irq;
    @(posedge clk) disable iff (rst) $rose(psmIrq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_batt;
    @(posedge clk) disable iff (rst) $rose(batterySwitchReq);
  endproperty
  c_cov_batt: cover property (p_cov_batt);

endmodule // pmcs_top

// [sim/testbench.sv]
// Self-checking testbench for the power management configuration and status block.
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module testbench;
  logic                   clk;
  logic                   rst;
  pmcs_pkg::pmcs_sfr_req_t sfrReq;
  logic [7:0]             sfrRdData;
  logic                   pllFaultAck;
  logic                   deepSleep;
  logic [7:0]             psmFlags;
  logic                   railOnMainPin;
  logic                   mainReadyPin;
  logic                   pllUnlockedPin;
  logic                   rxPin;
  logic                   dcinBelowPin;
  logic                   mainLowPin;
  logic                   psmIrq;
  logic                   refPowerOn;
  logic                   batterySwitchReq;
  logic                   rxPinUart;
  logic                   rxWakeEnable;
  logic                   switchoverSet;
  logic                   dcinLowSet;
  int                     nMismatch;
  int                     checks;
  int                     swCnt;
  int                     dcCnt;
  int                     enBits [6] = '{7, 5, 3, 2, 1, 0};

  pmcs_top pmcs_top_inst (
    .clk              (clk),
    .rst              (rst),
    .sfrReq           (sfrReq),
    .sfrRdData        (sfrRdData),
    .pllFaultAck      (pllFaultAck),
    .deepSleep        (deepSleep),
    .psmFlags         (psmFlags),
    .railOnMainPin    (railOnMainPin),
    .mainReadyPin     (mainReadyPin),
    .pllUnlockedPin   (pllUnlockedPin),
    .rxPin            (rxPin),
    .dcinBelowPin     (dcinBelowPin),
    .mainLowPin       (mainLowPin),
    .psmIrq           (psmIrq),
    .refPowerOn       (refPowerOn),
    .batterySwitchReq (batterySwitchReq),
    .rxPinUart        (rxPinUart),
    .rxWakeEnable     (rxWakeEnable),
    .switchoverSet    (switchoverSet),
    .dcinLowSet       (dcinLowSet)
  );

  always #5 clk = ~clk;

  // Set pulses last one cycle; sampling mid-cycle keeps the count clear of the launching edge.
  always @(negedge clk)
  begin
    if (switchoverSet === 1'b1) swCnt++;
    if (dcinLowSet === 1'b1) dcCnt++;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    sfrReq.wrEn   = 1'b1;
    sfrReq.addr   = addr;
    sfrReq.wrData = data;
    @(posedge clk);
    #1;
    sfrReq.wrEn = 1'b0;
  endtask

  // Read data is registered, so it is looked at in the cycle after the strobe.
  task automatic rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    #1;
    sfrReq.rdEn = 1'b1;
    sfrReq.addr = addr;
    @(posedge clk);
    #1;
    sfrReq.rdEn = 1'b0;
    chk(name, sfrRdData, exp);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    nMismatch++;
    stop_test();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    sfrReq = '0;
    pllFaultAck = 1'b0;
    deepSleep = 1'b0;
    psmFlags = 8'h00;
    railOnMainPin = 1'b1;
    mainReadyPin = 1'b1;
    pllUnlockedPin = 1'b0;
    rxPin = 1'b1;
    dcinBelowPin = 1'b0;
    mainLowPin = 1'b0;
    nMismatch = 0;
    checks = 0;
    swCnt = 0;
    dcCnt = 0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;

    rd("status reset", `PMCS_ADDR_CFG_STATUS, 8'h60);
    rd("irq en reset", `PMCS_ADDR_IRQ_EN, 8'h00);
    rd("policy reset", `PMCS_ADDR_BATT_SWITCH, 8'h00);
    rd("scratch reset", `PMCS_ADDR_SCRATCH, 8'h00);
    chk("refPowerOn reset", {7'h00, refPowerOn}, 8'h01);
    chk("psmIrq reset", {7'h00, psmIrq}, 8'h00);
    $display("test reset done");

    wr(`PMCS_ADDR_SCRATCH, 8'h5A);
    rd("scratch 5A", `PMCS_ADDR_SCRATCH, 8'h5A);
    wr(`PMCS_ADDR_SCRATCH, 8'hA5);
    wr(8'hFC, 8'hFF);
    rd("unmapped", 8'hFC, 8'h00);
    rd("scratch A5", `PMCS_ADDR_SCRATCH, 8'hA5);
    $display("test scratch done");

    wr(`PMCS_ADDR_IRQ_EN, 8'hEF);
    rd("irq en mask", `PMCS_ADDR_IRQ_EN, 8'hAF);
    wr(`PMCS_ADDR_IRQ_EN, 8'h40);
    psmFlags = 8'hFF;
    cyc(2);
    chk("irq reserved en", {7'h00, psmIrq}, 8'h00);
    foreach (enBits[i])
    begin
      wr(`PMCS_ADDR_IRQ_EN, 8'h01 << enBits[i]);
      psmFlags = ~(8'h01 << enBits[i]);
      cyc(2);
      chk("irq other flags", {7'h00, psmIrq}, 8'h00);
      psmFlags = 8'h01 << enBits[i];
      cyc(2);
      chk("irq own flag", {7'h00, psmIrq}, 8'h01);
    end
    psmFlags = 8'h00;
    cyc(2);
    chk("irq cleared", {7'h00, psmIrq}, 8'h00);
    $display("test interrupt done");

    for (int p = 0; p < 4; p++)
    begin
      wr(`PMCS_ADDR_BATT_SWITCH, 8'(p));
      rd("policy", `PMCS_ADDR_BATT_SWITCH, 8'(p));
      for (int c = 0; c < 4; c++)
      begin
        mainLowPin = c[1];
        dcinBelowPin = c[0];
        cyc(8);
        chk("battery req", {7'h00, batterySwitchReq},
            {7'h00, (p < 2) && c[1] && (p == 0 || c[0])});
      end
    end
    mainLowPin = 1'b0;
    dcinBelowPin = 1'b0;
    cyc(8);
    chk("dcin low pulses", 8'(dcCnt), 8'h08);
    $display("test switchover policy done");

    wr(`PMCS_ADDR_CFG_STATUS, 8'h00);
    // Bit 2 stays clear, so only the four function codes are walked.
    for (int f = 0; f < 4; f++)
    begin
      wr(`PMCS_ADDR_CFG_STATUS, 8'(f));
      cyc(1);
      chk("rx uart", {7'h00, rxPinUart}, {7'h00, f == 1 || f == 3});
      chk("rx wake en", {7'h00, rxWakeEnable}, {7'h00, f == 3});
    end
    wr(`PMCS_ADDR_CFG_STATUS, 8'h01);
    deepSleep = 1'b1;
    cyc(2);
    chk("ref off asleep", {7'h00, refPowerOn}, 8'h00);
    rxPin = 1'b0;
    cyc(8);
    rd("no wake", `PMCS_ADDR_CFG_STATUS, 8'h61);
    wr(`PMCS_ADDR_CFG_STATUS, 8'h03);
    rxPin = 1'b1;
    cyc(8);
    rd("wake set", `PMCS_ADDR_CFG_STATUS, 8'hE3);
    rd("scratch asleep", `PMCS_ADDR_SCRATCH, 8'hA5);
    wr(`PMCS_ADDR_CFG_STATUS, 8'h0B);
    cyc(2);
    chk("ref kept asleep", {7'h00, refPowerOn}, 8'h01);
    deepSleep = 1'b0;
    rd("wake cleared", `PMCS_ADDR_CFG_STATUS, 8'h6B);
    $display("test receive and reference done");

    pllUnlockedPin = 1'b1;
    cyc(8);
    rd("pll lost", `PMCS_ADDR_CFG_STATUS, 8'h7B);
    pllUnlockedPin = 1'b0;
    cyc(8);
    rd("pll held", `PMCS_ADDR_CFG_STATUS, 8'h7B);
    pllFaultAck = 1'b1;
    cyc(1);
    pllFaultAck = 1'b0;
    rd("pll acked", `PMCS_ADDR_CFG_STATUS, 8'h6B);
    $display("test pll done");

    railOnMainPin = 1'b0;
    cyc(8);
    chk("switchover pulse", 8'(swCnt), 8'h01);
    rd("rail battery", `PMCS_ADDR_CFG_STATUS, 8'h2B);
    mainReadyPin = 1'b0;
    cyc(8);
    rd("main not ready", `PMCS_ADDR_CFG_STATUS, 8'h0B);
    railOnMainPin = 1'b1;
    mainReadyPin = 1'b1;
    cyc(8);
    chk("no pulse on return", 8'(swCnt), 8'h01);
    rd("rail main", `PMCS_ADDR_CFG_STATUS, 8'h6B);
    $display("test supply status done");
    stop_test();
  end
endmodule // testbench
